/* File: rtl/ccw_card_csc_irq_and_window_enable.sv */
// Status-change interrupt configuration and card window enable registers
//
// Function
// - Route code 0000 with diag bit 5 set: interrupts to PCI, legacy bit ignored.
// - Route code 0000 with diag bit 5 clear: no ISA IRQ; PCI only if legacy bit.
// - Codes 0001 IRQ1, 0010 SMI, 0011 IRQ3, 0100 IRQ4, 0110 IRQ6.
// - Detect mask set: any card-detect line change raises status change; resets 0.
// - Ready mask set: READY rising edge raises status change; resets 0.
// - Battery warn mask set: warning raises status change; resets 0.
// - Battery dead mask set: dead battery or STSCHG raises status change.
// - Mask bits clear on global reset only while wake enabled, else either reset.
// - Cycles to a window whose enable is 0 are never acknowledged.
// - After reset all windows are disabled and enable bits read 0.
// - Bit 7 enables I/O window 1, bit 6 enables I/O window 0.
// - Bits 4..0 enable memory windows 4..0.
// - Window enable bit 5 is reserved and reads 0.
// - Masked flags read 0; enabled sources set their flag when active.
// - Legacy PCI-route bit matters only with route code 0000 and diag bit 5 clear; set routes to PCI.
`timescale 1ns/10ps
`default_nettype none
`include "ccw_regs.svh"
module ccw_card_csc_irq_and_window_enable (
    // Clock and resets
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst,
    input  wire logic               i_global_reset_in,
    input  wire logic               i_bus_reset_in,
    input  wire logic               i_pme_enable,
    // Register access
    input  wire logic               i_reg_wr,
    input  wire logic               i_reg_rd,
    input  wire ccw_pkg::ccw_addr_t i_reg_addr,
    input  wire ccw_pkg::ccw_byte_t i_reg_wdata,
    output ccw_pkg::ccw_byte_t      o_reg_rdata,
    output logic                    o_reg_rvalid,
    // Routing controls from other registers
    input  wire logic               i_diag_route_ctl,
    input  wire logic               i_legacy_pci_route_bit,
    input  wire logic               i_flag_clear_by_write,
    // Card status pins (asynchronous)
    input  wire logic [1:0]         i_card_detect_n,
    input  wire logic               i_card_ready,
    input  wire logic               i_battery_warn,
    input  wire logic               i_battery_dead_stschg,
    // Window decode from the address comparators
    input  wire logic [1:0]         i_io_window_hit,
    input  wire logic [4:0]         i_mem_window_hit,
    input  wire logic               i_cycle_req,
    output logic                    o_cycle_ack,
    // Status-change interrupt outputs
    output logic                    o_card_status_change_pci,
    output logic                    o_card_status_change_smi,
    output ccw_pkg::ccw_irq_vec_t   o_card_status_change_irq,
    output ccw_pkg::ccw_byte_t      o_window_enable
);
    import ccw_pkg::*;

    typedef struct packed {
        ccw_byte_t    cfg;
        ccw_byte_t    win;
        logic [3:0]   flags;
        logic [1:0]   cd_prev;
        logic         rdy_prev;
        ccw_byte_t    rdata;
        logic         rvalid;
        logic         ack;
        logic         pci;
        logic         smi;
        ccw_irq_vec_t irq;
    } ccw_state_s;

    ccw_state_s st_r;
    ccw_state_s st_nxt;
    logic [4:0] pin_s;
    logic       global_reset_in_s;
    logic       bus_reset_in_s;

    ccw_sync2 #(.W(5)) u_pins (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        // Detect lines enter inverted so an empty socket matches the cleared history: no false change after reset
        .i_async   ({~i_card_detect_n, i_card_ready, i_battery_warn, i_battery_dead_stschg}),
        .o_sync    (pin_s)
    );

    ccw_sync2 #(.W(2)) u_rsts (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_async   ({i_global_reset_in, i_bus_reset_in}),
        .o_sync    ({global_reset_in_s, bus_reset_in_s})
    );

    // Decodes a route code other than 0000 and SMI into a one-hot IRQ vector
    function automatic ccw_irq_vec_t route_decode(input logic [3:0] code);
        ccw_irq_vec_t v;
        v = '0;
        if (code != `CCW_CODE_NONE && code != `CCW_CODE_SMI) begin
            v[code] = 1'b1;
        end
        return v & ~`CCW_IRQ_RSVD_MASK;
    endfunction

    // Any enabled window claims the cycle; shared by the acknowledge and its check
    function automatic logic window_hit(input logic [1:0] io, input logic [4:0] mem, input ccw_byte_t en);
        return |(io & en[7:6]) | |(mem & en[4:0]);
    endfunction

    logic [3:0] route_code;
    logic       any_flag;
    logic       ctx_clear;
    logic [3:0] evt;
    logic       hit_enabled;

    assign route_code = st_r.cfg[`CCW_ROUTE_HI:`CCW_ROUTE_LO];
    assign any_flag   = |st_r.flags;

    always_comb begin
        st_nxt = st_r;
        // Context bits survive a bus reset while wake is armed
        ctx_clear = global_reset_in_s | (bus_reset_in_s & ~i_pme_enable);
        evt[`CCW_BIT_DETECT]  = pin_s[4:3] != st_r.cd_prev;
        evt[`CCW_BIT_READY]   = pin_s[2] & ~st_r.rdy_prev;
        evt[`CCW_BIT_BATWARN] = pin_s[1];
        evt[`CCW_BIT_BATDEAD] = pin_s[0];
        st_nxt.cd_prev  = pin_s[4:3];
        st_nxt.rdy_prev = pin_s[2];
        st_nxt.rvalid   = i_reg_rd;
        st_nxt.rdata    = '0;
        if (i_reg_rd) begin
            case (i_reg_addr)
                `CCW_OFS_IRQ_CONFIG:    st_nxt.rdata = st_r.cfg;
                `CCW_OFS_WIN_ENABLE:    st_nxt.rdata = st_r.win & `CCW_WIN_WR_MASK;
                `CCW_OFS_STATUS_CHANGE: st_nxt.rdata = {4'h0, st_r.flags};
                default:                st_nxt.rdata = '0;
            endcase
        end
        // Flag clearing by read or by write-one, then sets win
        if (i_reg_rd && !i_flag_clear_by_write && i_reg_addr == `CCW_OFS_STATUS_CHANGE) begin
            st_nxt.flags = '0;
        end
        if (i_reg_wr && i_flag_clear_by_write && i_reg_addr == `CCW_OFS_STATUS_CHANGE) begin
            st_nxt.flags = st_r.flags & ~i_reg_wdata[3:0];
        end
        if (i_reg_wr && i_reg_addr == `CCW_OFS_IRQ_CONFIG) begin
            st_nxt.cfg = i_reg_wdata;
        end
        if (i_reg_wr && i_reg_addr == `CCW_OFS_WIN_ENABLE) begin
            st_nxt.win = i_reg_wdata & `CCW_WIN_WR_MASK;
        end
        if (ctx_clear) begin
            st_nxt.cfg = st_nxt.cfg & ~`CCW_MASK_FIELD;
        end
        st_nxt.flags = (st_nxt.flags | (evt & st_r.cfg[3:0])) & st_nxt.cfg[3:0];
        // Window acknowledge gated by the enables
        hit_enabled = window_hit(i_io_window_hit, i_mem_window_hit, st_r.win);
        st_nxt.ack  = i_cycle_req & hit_enabled;
        // Interrupt routing
        st_nxt.pci = 1'b0;
        st_nxt.smi = 1'b0;
        st_nxt.irq = '0;
        if (route_code == `CCW_CODE_NONE) begin
            st_nxt.pci = any_flag & (i_diag_route_ctl | i_legacy_pci_route_bit);
        end else if (route_code == `CCW_CODE_SMI) begin
            st_nxt.smi = any_flag;
        end else begin
            st_nxt.irq = any_flag ? route_decode(route_code) : '0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            st_r     <= '0;
            st_r.cfg <= `CCW_RST_IRQ_CONFIG;
            st_r.win <= `CCW_RST_WIN_ENABLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_reg_rdata              = st_r.rdata;
    assign o_reg_rvalid             = st_r.rvalid;
    assign o_cycle_ack              = st_r.ack;
    assign o_card_status_change_pci = st_r.pci;
    assign o_card_status_change_smi = st_r.smi;
    assign o_card_status_change_irq = st_r.irq;
    assign o_window_enable          = st_r.win;

    property p_ack_needs_enable;
        @(posedge i_clk_sys) disable iff (i_rst)
        o_cycle_ack |-> $past(window_hit(i_io_window_hit, i_mem_window_hit, st_r.win));
    endproperty
    a_ack_needs_enable: assert property (p_ack_needs_enable) else $error("ack to disabled window");

    property p_rsvd_zero;
        @(posedge i_clk_sys) disable iff (i_rst)
        o_window_enable[`CCW_WIN_RSVD_BIT] == 1'b0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved window bit set");

    property p_reset_disables;
        @(posedge i_clk_sys) i_rst |=> o_window_enable == 8'h00 && st_r.cfg == 8'h00;
    endproperty
    a_reset_disables: assert property (p_reset_disables) else $error("windows not disabled by reset");

    property p_masked_flag_zero;
        @(posedge i_clk_sys) disable iff (i_rst)
        (st_r.flags & ~st_r.cfg[3:0]) == 4'h0;
    endproperty
    a_masked_flag_zero: assert property (p_masked_flag_zero) else $error("masked flag set");

    property p_ready_rise;
        @(posedge i_clk_sys) disable iff (i_rst)
        (pin_s[2] && !st_r.rdy_prev && st_r.cfg[`CCW_BIT_READY] && st_nxt.cfg[`CCW_BIT_READY])
            |=> st_r.flags[`CCW_BIT_READY];
    endproperty
    a_ready_rise: assert property (p_ready_rise) else $error("ready rise lost");

    property p_detect_change;
        @(posedge i_clk_sys) disable iff (i_rst)
        (pin_s[4:3] != st_r.cd_prev && st_r.cfg[`CCW_BIT_DETECT] && st_nxt.cfg[`CCW_BIT_DETECT])
            |=> st_r.flags[`CCW_BIT_DETECT];
    endproperty
    a_detect_change: assert property (p_detect_change) else $error("detect change lost");

    property p_pme_keeps;
        @(posedge i_clk_sys) disable iff (i_rst)
        (bus_reset_in_s && !global_reset_in_s && i_pme_enable && !i_reg_wr) |=> st_r.cfg[3:0] == $past(st_r.cfg[3:0]);
    endproperty
    a_pme_keeps: assert property (p_pme_keeps) else $error("mask lost on bus reset");

    property p_global_reset_in_clears;
        @(posedge i_clk_sys) disable iff (i_rst)
        global_reset_in_s |=> st_r.cfg[3:0] == 4'h0;
    endproperty
    a_global_reset_in_clears: assert property (p_global_reset_in_clears) else $error("mask kept on global reset");

    property p_route_zero;
        @(posedge i_clk_sys) disable iff (i_rst)
        (route_code == 4'h0 && any_flag && i_diag_route_ctl) |=> o_card_status_change_pci && o_card_status_change_irq == 16'h0;
    endproperty
    a_route_zero: assert property (p_route_zero) else $error("default route not to PCI");

    property p_route_irq;
        @(posedge i_clk_sys) disable iff (i_rst)
        (route_code == 4'h3 && any_flag) |=> o_card_status_change_irq == 16'h0008 && !o_card_status_change_pci;
    endproperty
    a_route_irq: assert property (p_route_irq) else $error("code 3 not IRQ3");

    property p_route_smi;
        @(posedge i_clk_sys) disable iff (i_rst)
        (route_code == `CCW_CODE_SMI && any_flag)
            |=> o_card_status_change_smi && !o_card_status_change_pci && o_card_status_change_irq == 16'h0000;
    endproperty
    a_route_smi: assert property (p_route_smi) else $error("code 2 not SMI");

    property p_route_none;
        @(posedge i_clk_sys) disable iff (i_rst)
        (route_code == `CCW_CODE_NONE && any_flag && !i_diag_route_ctl && !i_legacy_pci_route_bit)
            |=> !o_card_status_change_pci && !o_card_status_change_smi && o_card_status_change_irq == 16'h0000;
    endproperty
    a_route_none: assert property (p_route_none) else $error("interrupt driven with no route");

    property p_legacy_route;
        @(posedge i_clk_sys) disable iff (i_rst)
        (route_code == `CCW_CODE_NONE && any_flag && !i_diag_route_ctl && i_legacy_pci_route_bit)
            |=> o_card_status_change_pci;
    endproperty
    a_legacy_route: assert property (p_legacy_route) else $error("legacy bit did not route to PCI");

    property p_route_other;
        @(posedge i_clk_sys) disable iff (i_rst)
        (route_code != `CCW_CODE_NONE && route_code != `CCW_CODE_SMI && any_flag)
            |=> $onehot(o_card_status_change_irq) && !o_card_status_change_pci && !o_card_status_change_smi;
    endproperty
    a_route_other: assert property (p_route_other) else $error("IRQ code not one-hot");

    property p_no_flag_quiet;
        @(posedge i_clk_sys) disable iff (i_rst)
        !any_flag
            |=> !o_card_status_change_pci && !o_card_status_change_smi && o_card_status_change_irq == 16'h0000;
    endproperty
    a_no_flag_quiet: assert property (p_no_flag_quiet) else $error("interrupt with no flag");

    property p_batwarn_set;
        @(posedge i_clk_sys) disable iff (i_rst)
        (pin_s[1] && st_r.cfg[`CCW_BIT_BATWARN] && st_nxt.cfg[`CCW_BIT_BATWARN])
            |=> st_r.flags[`CCW_BIT_BATWARN];
    endproperty
    a_batwarn_set: assert property (p_batwarn_set) else $error("battery warning lost");

    property p_batdead_set;
        @(posedge i_clk_sys) disable iff (i_rst)
        (pin_s[0] && st_r.cfg[`CCW_BIT_BATDEAD] && st_nxt.cfg[`CCW_BIT_BATDEAD])
            |=> st_r.flags[`CCW_BIT_BATDEAD];
    endproperty
    a_batdead_set: assert property (p_batdead_set) else $error("battery dead lost");

    property p_win_write;
        @(posedge i_clk_sys) disable iff (i_rst)
        (i_reg_wr && i_reg_addr == `CCW_OFS_WIN_ENABLE)
            |=> o_window_enable == ($past(i_reg_wdata) & `CCW_WIN_WR_MASK);
    endproperty
    a_win_write: assert property (p_win_write) else $error("window enable write lost");

    property p_win_read_rsvd;
        @(posedge i_clk_sys) disable iff (i_rst)
        (i_reg_rd && i_reg_addr == `CCW_OFS_WIN_ENABLE)
            |=> o_reg_rvalid && !o_reg_rdata[`CCW_WIN_RSVD_BIT];
    endproperty
    a_win_read_rsvd: assert property (p_win_read_rsvd) else $error("reserved bit read as one");

    property p_bus_reset_clears;
        @(posedge i_clk_sys) disable iff (i_rst)
        (bus_reset_in_s && !i_pme_enable) |=> st_r.cfg[3:0] == 4'h0;
    endproperty
    a_bus_reset_clears: assert property (p_bus_reset_clears) else $error("mask kept on bus reset");
endmodule
`default_nettype wire

/* File: rtl/ccw_regs.svh */
// Offsets, field positions, reset values and codes of the status-change and window enable registers
`ifndef CCW_REGS_SVH
`define CCW_REGS_SVH

`define CCW_OFS_IRQ_CONFIG      12'h805
`define CCW_OFS_WIN_ENABLE      12'h806
`define CCW_OFS_STATUS_CHANGE   12'h804
`define CCW_RST_IRQ_CONFIG      8'h00
`define CCW_RST_WIN_ENABLE      8'h00
`define CCW_ROUTE_HI            7
`define CCW_ROUTE_LO            4
`define CCW_BIT_DETECT          3
`define CCW_BIT_READY           2
`define CCW_BIT_BATWARN         1
`define CCW_BIT_BATDEAD         0
`define CCW_MASK_FIELD          8'h0f
`define CCW_WIN_RSVD_BIT        5
`define CCW_WIN_WR_MASK         8'hdf
`define CCW_CODE_NONE           4'h0
`define CCW_CODE_SMI            4'h2
`define CCW_IRQ_RSVD_MASK       16'h0005

`endif

/* File: rtl/ccw_pkg.sv */
// Types shared by the status-change and window enable register block
package ccw_pkg;
    typedef logic [7:0]  ccw_byte_t;
    typedef logic [11:0] ccw_addr_t;
    typedef logic [15:0] ccw_irq_vec_t;
endpackage

/* File: rtl/ccw_sync2.sv */
// Two-flop synchroniser for a group of card pins
`timescale 1ns/10ps
`default_nettype none
module ccw_sync2 #(
    parameter int W = 5
) (
    // Clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    // Pins and their synchronised copy
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } ccw_sync_s;

    ccw_sync_s st_r;
    ccw_sync_s st_nxt;

    // Only the second stage is ever read outside
    always_comb begin
        st_nxt      = st_r;
        st_nxt.meta = i_async;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_sync = st_r.sync;
endmodule
`default_nettype wire

/* File: tb/ccw_card_model.sv */
// Behavioural 16-bit card standing in the socket: detect, ready and battery pins
`timescale 1ns/10ps
`default_nettype none
module ccw_card_model (
    // Card pins toward the socket
    output logic [1:0] o_card_detect_n,
    output logic       o_card_ready,
    output logic       o_battery_warn,
    output logic       o_battery_dead_stschg
);
    // Empty socket: detect lines sit at their pull-up level
    initial begin
        o_card_detect_n       = 2'h3;
        o_card_ready          = 1'h0;
        o_battery_warn        = 1'h0;
        o_battery_dead_stschg = 1'h0;
    end

    // Pins change together, as a real card moves them between host samples
    task automatic set_pins(input logic [1:0] det_n, input logic rdy, input logic warn, input logic dead);
        o_card_detect_n       = det_n;
        o_card_ready          = rdy;
        o_battery_warn        = warn;
        o_battery_dead_stschg = dead;
    endtask
endmodule
`default_nettype wire

/* File: tb/ccw_card_csc_irq_and_window_enable_test.sv */
// Self-checking bench of the status-change and window enable registers
`timescale 1ns/10ps
`default_nettype none
module ccw_card_csc_irq_and_window_enable_test;
    import ccw_pkg::*;
    logic         i_clk_sys = 1'b0;
    logic         i_rst = 1'b1, i_global_reset_in = 1'b0, i_bus_reset_in = 1'b0, i_pme_enable = 1'b0;
    logic         i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_cycle_req = 1'b0;
    ccw_addr_t    i_reg_addr = 12'h000;
    ccw_byte_t    i_reg_wdata = 8'h00, o_reg_rdata, o_window_enable;
    logic         i_diag_route_ctl = 1'b0, i_legacy_pci_route_bit = 1'b0, i_flag_clear_by_write = 1'b1;
    logic [1:0]   i_card_detect_n, i_io_window_hit = 2'h0;
    logic         i_card_ready, i_battery_warn, i_battery_dead_stschg;
    logic [4:0]   i_mem_window_hit = 5'h00;
    logic         o_reg_rvalid, o_cycle_ack, o_card_status_change_pci, o_card_status_change_smi;
    ccw_irq_vec_t o_card_status_change_irq;
    int           n_mismatch = 0;
    int           checks = 0;
    logic [15:0]  rows [5] = '{16'hffdf, 16'h2000, 16'hc0c0, 16'h1f1f, 16'ha585};
    logic [7:0]   ens [3] = '{8'h00, 8'h95, 8'h4a};

    always #25 i_clk_sys = ~i_clk_sys;

    ccw_card_model u_card (.o_card_detect_n(i_card_detect_n), .o_card_ready(i_card_ready),
        .o_battery_warn(i_battery_warn), .o_battery_dead_stschg(i_battery_dead_stschg));

    ccw_card_csc_irq_and_window_enable u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_global_reset_in(i_global_reset_in), .i_bus_reset_in(i_bus_reset_in), .i_pme_enable(i_pme_enable),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .i_diag_route_ctl(i_diag_route_ctl),
        .i_legacy_pci_route_bit(i_legacy_pci_route_bit), .i_flag_clear_by_write(i_flag_clear_by_write),
        .i_card_detect_n(i_card_detect_n), .i_card_ready(i_card_ready), .i_battery_warn(i_battery_warn),
        .i_battery_dead_stschg(i_battery_dead_stschg), .i_io_window_hit(i_io_window_hit),
        .i_mem_window_hit(i_mem_window_hit), .i_cycle_req(i_cycle_req), .o_cycle_ack(o_cycle_ack),
        .o_card_status_change_pci(o_card_status_change_pci), .o_card_status_change_smi(o_card_status_change_smi),
        .o_card_status_change_irq(o_card_status_change_irq), .o_window_enable(o_window_enable));

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(negedge i_clk_sys);
        i_reg_wr = 1'b0;
    endtask

    // Read data stands for one cycle only, so it is taken at the next falling edge
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(negedge i_clk_sys);
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        @(negedge i_clk_sys);
        i_reg_rd = 1'b0;
        chk({9'h0, o_reg_rvalid, o_reg_rdata}, {9'h1, e});
    endtask

    // Reset pins are synchronised, so they are held well past the two-flop delay
    task automatic pulse_reset(input logic glob);
        @(negedge i_clk_sys);
        i_global_reset_in = glob;
        i_bus_reset_in = ~glob;
        repeat (4) @(negedge i_clk_sys);
        i_global_reset_in = 1'b0;
        i_bus_reset_in = 1'b0;
        repeat (4) @(negedge i_clk_sys);
    endtask

    // Expected {pci, smi, irq} for one route code
    function automatic logic [17:0] route_exp(input logic [3:0] c, input logic dg, input logic lg);
        logic [17:0] r;
        r = 18'h0;
        if (c == 4'h0) r[17] = dg | lg;
        else if (c == 4'h2) r[16] = 1'b1;
        else r[c] = 1'b1;
        return r;
    endfunction

    task automatic final_report();
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk_sys);
        n_mismatch++;
        final_report();
    end

    initial begin
        repeat (8) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_rst = 1'b0;
        chk({o_card_status_change_pci, o_card_status_change_smi, o_card_status_change_irq}, 18'h0);
        chk({10'h0, o_window_enable}, 18'h0);
        rd(12'h806, 8'h00);
        rd(12'h805, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(12'h806, rows[i][15:8]);
            chk({10'h0, o_window_enable}, {10'h0, rows[i][7:0]});
            rd(12'h806, rows[i][7:0]);
        end
        // Unmapped place: write ignored, reads zero
        wr(12'h8ff, 8'hff);
        rd(12'h8ff, 8'h00);
        rd(12'h805, 8'h00);
        for (int k = 0; k < 3; k++) begin
            wr(12'h806, ens[k]);
            for (int i = 0; i < 7; i++) begin
                @(negedge i_clk_sys);
                {i_io_window_hit, i_mem_window_hit} = 7'h1 << i;
                i_cycle_req = 1'b1;
                @(negedge i_clk_sys);
                chk({17'h0, o_cycle_ack}, {17'h0, (i < 5) ? ens[k][i] : ens[k][i + 1]});
            end
            i_cycle_req = 1'b0;
        end
        // Battery warning is level-set, so its flag holds the interrupt up through the route sweep
        u_card.set_pins(2'h3, 1'b0, 1'b1, 1'b0);
        wr(12'h805, 8'h02);
        repeat (6) @(negedge i_clk_sys);
        rd(12'h804, 8'h02);
        for (int c = 0; c < 32; c++) begin
            i_legacy_pci_route_bit = c[4];
            wr(12'h805, {c[3:0], 4'h2});
            repeat (3) @(negedge i_clk_sys);
            chk({o_card_status_change_pci, o_card_status_change_smi, o_card_status_change_irq},
                route_exp(c[3:0], 1'b0, c[4]));
        end
        i_diag_route_ctl = 1'b1;
        i_legacy_pci_route_bit = 1'b0;
        wr(12'h805, 8'h02);
        repeat (3) @(negedge i_clk_sys);
        chk({o_card_status_change_pci, o_card_status_change_smi, o_card_status_change_irq}, 18'h20000);
        wr(12'h805, 8'h00);
        repeat (3) @(negedge i_clk_sys);
        rd(12'h804, 8'h00);
        chk({o_card_status_change_pci, o_card_status_change_smi, o_card_status_change_irq}, 18'h0);
        wr(12'h805, 8'h08);
        u_card.set_pins(2'h0, 1'b0, 1'b0, 1'b0);
        repeat (6) @(negedge i_clk_sys);
        rd(12'h804, 8'h08);
        // Both clear modes: write-one first, then clear on read
        wr(12'h804, 8'h08);
        rd(12'h804, 8'h00);
        i_flag_clear_by_write = 1'b0;
        u_card.set_pins(2'h3, 1'b0, 1'b0, 1'b0);
        repeat (6) @(negedge i_clk_sys);
        rd(12'h804, 8'h08);
        rd(12'h804, 8'h00);
        i_flag_clear_by_write = 1'b1;
        wr(12'h805, 8'h04);
        u_card.set_pins(2'h0, 1'b1, 1'b0, 1'b0);
        repeat (6) @(negedge i_clk_sys);
        rd(12'h804, 8'h04);
        wr(12'h805, 8'h01);
        u_card.set_pins(2'h0, 1'b1, 1'b0, 1'b1);
        repeat (6) @(negedge i_clk_sys);
        rd(12'h804, 8'h01);
        // Wake enabled: the bus reset must spare the masks, the global one must not
        wr(12'h805, 8'h0f);
        i_pme_enable = 1'b1;
        pulse_reset(1'b0);
        rd(12'h805, 8'h0f);
        pulse_reset(1'b1);
        rd(12'h805, 8'h00);
        wr(12'h805, 8'h0f);
        i_pme_enable = 1'b0;
        pulse_reset(1'b0);
        rd(12'h805, 8'h00);
        final_report();
    end
endmodule
`default_nettype wire
